// ---- common/scfg_link_if.sv ----
// serial link between host controller and config register device
`timescale 1ns/1ps
interface scfg_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe_n;
  logic reset_n;
  modport dev (
    input sck,
    input cs_n,
    input si,
    input reset_n,
    output so,
    output so_oe_n
  );
  modport host (
    output sck,
    output cs_n,
    output si,
    output reset_n,
    input so,
    input so_oe_n
  );
endinterface

// ---- common/scfg_pkg.sv ----
// shared constants and types for the config register four/five serial link
package scfg_pkg;
  // =====================================================
  // clocking and timing
  localparam int CLK_MHZ = 125;
  localparam int WAKE_PULSE_NS = 100;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int EXIT_NS = 1000;
  localparam int EXIT_CYC = (EXIT_NS * CLK_MHZ + 999) / 1000;
  localparam int HWRST_NS = 100;
  localparam int HWRST_CYC = (HWRST_NS * CLK_MHZ + 999) / 1000;
  localparam int SCK_HALF = 4;
  localparam int SCK_MHZ = CLK_MHZ / (2 * SCK_HALF);
  localparam int ZERO_LAT_MAX_MHZ = 50;
  localparam int TIMER_W = 10;
  // =====================================================
  // opcodes
  localparam logic [7:0] OP_WRITE_ANY = 8'h71;
  localparam logic [7:0] OP_READ_ANY = 8'h65;
  localparam logic [7:0] OP_READ_CONFIG_FIVE = 8'h5E;
  localparam logic [7:0] OP_READ_CONFIG_FOUR = 8'h45;
  localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] OP_READ_CONFIG_ONE = 8'h35;
  localparam logic [7:0] OP_READ_CONFIG_TWO = 8'h3F;
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;
  // =====================================================
  // register addresses for write-any and read-any
  localparam logic [23:0] ADDR_CFG4_NV = 24'h000005;
  localparam logic [23:0] ADDR_CFG4_V = 24'h070005;
  localparam logic [23:0] ADDR_CFG5_NV = 24'h000006;
  localparam logic [23:0] ADDR_CFG5_V = 24'h070006;
  // =====================================================
  // field layout and factory values
  localparam int DRV_MSB = 7;
  localparam int DRV_LSB = 5;
  localparam int PDR_BIT = 2;
  localparam int LAT_MSB = 7;
  localparam int LAT_LSB = 6;
  localparam logic [2:0] DRV_FACTORY_CODE = 3'h0;
  localparam logic [2:0] DRV_FACTORY_EQUIV = 3'h4;
  localparam logic [7:0] CFG4_FACTORY = 8'h08;
  localparam logic [7:0] CFG4_WMASK = 8'hEC;
  localparam logic [7:0] CFG5_FACTORY = 8'h00;
  localparam logic [7:0] CFG5_WMASK = 8'hC0;
  // =====================================================
  // host command kinds
  typedef enum logic [2:0] {
    K_OPCODE_ONLY,
    K_WRITE_ANY,
    K_READ_ANY,
    K_READ_REG,
    K_WAKE,
    K_HW_RESET
  } scfg_kind_t;
endpackage

// ---- hdl/scfg_device.sv ----
// device end: config registers four and five behind a single-lane serial link
`timescale 1ns/1ps
module scfg_device (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  scfg_link_if.dev LINK,
  output logic [2:0] DRIVE_CODE,
  output logic POWERED_DOWN,
  output logic [1:0] LATENCY
);
  typedef enum {D_IDLE, D_OPC, D_ADDR, D_WDATA, D_DUMMY, D_RDATA, D_SKIP, D_DPD, D_EXIT} scfg_dstate_t;

  scfg_dstate_t state, next_state;
  logic [7:0] op, next_op, sh, next_sh, tx, next_tx;
  logic [23:0] addr, next_addr;
  logic [5:0] bitcnt, next_bitcnt;
  logic [scfg_pkg::TIMER_W-1:0] tcnt, next_tcnt;
  logic [7:0] cfg4_nv, next_cfg4_nv, cfg4_v, next_cfg4_v;
  logic [7:0] cfg5_nv, next_cfg5_nv, cfg5_v, next_cfg5_v;
  logic boot, next_boot, so, next_so, so_oe_n, next_so_oe_n;
  logic sck_m, sck_s, sck_q, cs_m, cs_s, si_m, si_s, rst_m, rst_s, rst_q;
  logic rise, fall, sel, pin_release;
  logic [1:0] lat;

  // =====================================================
  // command decode helpers
  function automatic logic lat_read(input logic [7:0] o);
    lat_read = (o == scfg_pkg::OP_READ_STATUS_ONE) || (o == scfg_pkg::OP_READ_STATUS_TWO) ||
               (o == scfg_pkg::OP_READ_CONFIG_ONE) || (o == scfg_pkg::OP_READ_CONFIG_TWO) ||
               (o == scfg_pkg::OP_READ_CONFIG_FOUR) || (o == scfg_pkg::OP_READ_CONFIG_FIVE) ||
               (o == scfg_pkg::OP_READ_ANY);
  endfunction

  function automatic logic [7:0] any_reg(input logic [23:0] a, input logic [7:0] c4n, input logic [7:0] c4v,
                                          input logic [7:0] c5n, input logic [7:0] c5v);
    case (a)
      scfg_pkg::ADDR_CFG4_NV: any_reg = c4n;
      scfg_pkg::ADDR_CFG4_V: any_reg = c4v;
      scfg_pkg::ADDR_CFG5_NV: any_reg = c5n;
      scfg_pkg::ADDR_CFG5_V: any_reg = c5v;
      default: any_reg = 8'h00;
    endcase
  endfunction

  // =====================================================
  // pin synchronisers and edge finders
  always_ff @(posedge CLOCK) begin
    sck_m <= LINK.sck;
    sck_s <= sck_m;
    cs_m <= LINK.cs_n;
    cs_s <= cs_m;
    si_m <= LINK.si;
    si_s <= si_m;
    rst_m <= LINK.reset_n;
    rst_s <= rst_m;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sck_q <= 1'b0;
      rst_q <= 1'b1;
    end else begin
      sck_q <= sck_s;
      rst_q <= rst_s;
    end
  end

  assign sel = !cs_s;
  assign rise = sel && sck_s && !sck_q;
  assign fall = sel && !sck_s && sck_q;
  assign pin_release = rst_s && !rst_q;
  // one dummy count for every lane mode; only single lane is wired here
  assign lat = cfg5_v[scfg_pkg::LAT_MSB:scfg_pkg::LAT_LSB];

  // =====================================================
  // command engine and register copies
  always_comb begin
    next_state = state;
    next_op = op;
    next_sh = sh;
    next_tx = tx;
    next_addr = addr;
    next_bitcnt = bitcnt;
    next_tcnt = tcnt;
    next_cfg4_nv = cfg4_nv;
    next_cfg4_v = cfg4_v;
    next_cfg5_nv = cfg5_nv;
    next_cfg5_v = cfg5_v;
    next_boot = pin_release;
    next_so = so;
    next_so_oe_n = 1'b1;
    if (!rst_s) begin
      // pin reset held: commands ignored, copies reloaded at release
      next_state = D_IDLE;
      next_boot = 1'b0;
    end else if (boot) begin
      next_cfg4_v = cfg4_nv;
      next_cfg5_v = cfg5_nv;
      if (cfg4_nv[scfg_pkg::PDR_BIT] && !sel) begin
        next_state = D_DPD;
      end else begin
        next_state = sel ? D_SKIP : D_IDLE;
      end
    end else begin
      case (state)
        D_IDLE: begin
          next_bitcnt = 6'h0;
          if (sel) begin
            next_state = D_OPC;
          end
        end
        D_OPC: begin
          if (rise) begin
            next_sh = {sh[6:0], si_s};
            next_bitcnt = bitcnt + 6'h1;
            if (bitcnt == 6'd7) begin
              next_op = {sh[6:0], si_s};
              next_bitcnt = 6'h0;
              next_tx = ({sh[6:0], si_s} == scfg_pkg::OP_READ_CONFIG_FOUR) ? cfg4_v :
                        ({sh[6:0], si_s} == scfg_pkg::OP_READ_CONFIG_FIVE) ? cfg5_v : 8'h00;
              if ({sh[6:0], si_s} == scfg_pkg::OP_WRITE_ANY || {sh[6:0], si_s} == scfg_pkg::OP_READ_ANY) begin
                next_state = D_ADDR;
              end else if ({sh[6:0], si_s} == scfg_pkg::OP_SOFT_RESET) begin
                // software reset ignores the power-down bit
                next_cfg4_v = cfg4_nv;
                next_cfg5_v = cfg5_nv;
                next_state = D_SKIP;
              end else if (lat_read({sh[6:0], si_s})) begin
                next_state = (lat == 2'h0) ? D_RDATA : D_DUMMY;
              end else begin
                next_state = D_SKIP;
              end
            end
          end
        end
        D_ADDR: begin
          if (rise) begin
            next_addr = {addr[22:0], si_s};
            next_bitcnt = bitcnt + 6'h1;
            if (bitcnt == 6'd23) begin
              next_bitcnt = 6'h0;
              if (op == scfg_pkg::OP_WRITE_ANY) begin
                next_state = D_WDATA;
              end else begin
                next_tx = any_reg({addr[22:0], si_s}, cfg4_nv, cfg4_v, cfg5_nv, cfg5_v);
                next_state = (lat == 2'h0) ? D_RDATA : D_DUMMY;
              end
            end
          end
        end
        D_WDATA: begin
          if (rise) begin
            next_sh = {sh[6:0], si_s};
            next_bitcnt = bitcnt + 6'h1;
            if (bitcnt == 6'd7) begin
              next_state = D_SKIP;
              // bit three is stored as written; the host keeps it set
              case (addr)
                scfg_pkg::ADDR_CFG4_NV: next_cfg4_nv = {sh[6:0], si_s} & scfg_pkg::CFG4_WMASK;
                scfg_pkg::ADDR_CFG4_V: next_cfg4_v = {sh[6:0], si_s} & scfg_pkg::CFG4_WMASK;
                scfg_pkg::ADDR_CFG5_NV: next_cfg5_nv = {sh[6:0], si_s} & scfg_pkg::CFG5_WMASK;
                scfg_pkg::ADDR_CFG5_V: next_cfg5_v = {sh[6:0], si_s} & scfg_pkg::CFG5_WMASK;
                default: next_state = D_SKIP;
              endcase
            end
          end
        end
        D_DUMMY: begin
          if (rise) begin
            next_bitcnt = bitcnt + 6'h1;
            if (bitcnt == 6'({4'h0, lat} - 6'h1)) begin
              next_bitcnt = 6'h0;
              next_state = D_RDATA;
            end
          end
        end
        D_RDATA: begin
          next_so_oe_n = 1'b0;
          if (fall) begin
            // the byte repeats while the clock keeps running
            next_so = tx[7];
            next_tx = {tx[6:0], tx[7]};
          end
        end
        D_SKIP: begin
          next_so_oe_n = so_oe_n;
        end
        D_DPD: begin
          // commands ignored; only chip select width counts
          next_tcnt = sel ? tcnt + 1'b1 : '0;
          if (tcnt == scfg_pkg::TIMER_W'(scfg_pkg::WAKE_PULSE_CYC)) begin
            next_tcnt = '0;
            next_state = D_EXIT;
          end
        end
        D_EXIT: begin
          next_tcnt = tcnt + 1'b1;
          if (tcnt == scfg_pkg::TIMER_W'(scfg_pkg::EXIT_CYC - 1)) begin
            next_tcnt = '0;
            next_state = sel ? D_SKIP : D_IDLE;
          end
        end
        default: next_state = D_IDLE;
      endcase
      if (!sel && state != D_DPD && state != D_EXIT) begin
        next_state = D_IDLE;
        next_so_oe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state <= D_IDLE;
      op <= 8'h00;
      sh <= 8'h00;
      tx <= 8'h00;
      addr <= 24'h000000;
      bitcnt <= 6'h0;
      tcnt <= '0;
      cfg4_nv <= scfg_pkg::CFG4_FACTORY;
      cfg4_v <= scfg_pkg::CFG4_FACTORY;
      cfg5_nv <= scfg_pkg::CFG5_FACTORY;
      cfg5_v <= scfg_pkg::CFG5_FACTORY;
      boot <= 1'b1;
      so <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      state <= next_state;
      op <= next_op;
      sh <= next_sh;
      tx <= next_tx;
      addr <= next_addr;
      bitcnt <= next_bitcnt;
      tcnt <= next_tcnt;
      cfg4_nv <= next_cfg4_nv;
      cfg4_v <= next_cfg4_v;
      cfg5_nv <= next_cfg5_nv;
      cfg5_v <= next_cfg5_v;
      boot <= next_boot;
      so <= next_so;
      so_oe_n <= next_so_oe_n;
    end
  end

  // =====================================================
  // user-side status, one cycle behind the volatile copies and the engine state
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      DRIVE_CODE <= scfg_pkg::DRV_FACTORY_EQUIV;
      POWERED_DOWN <= 1'b0;
      LATENCY <= 2'h0;
    end else begin
      if (cfg4_v[scfg_pkg::DRV_MSB:scfg_pkg::DRV_LSB] == scfg_pkg::DRV_FACTORY_CODE) begin
        DRIVE_CODE <= scfg_pkg::DRV_FACTORY_EQUIV;
      end else begin
        DRIVE_CODE <= cfg4_v[scfg_pkg::DRV_MSB:scfg_pkg::DRV_LSB];
      end
      POWERED_DOWN <= (state == D_DPD) || (state == D_EXIT);
      LATENCY <= lat;
    end
  end

  assign LINK.so = so;
  assign LINK.so_oe_n = so_oe_n;
endmodule

// ---- hdl/scfg_host.sv ----
// host end: issues register commands, wake pulses and pin resets
`timescale 1ns/1ps
module scfg_host (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  scfg_link_if.host LINK,
  input wire logic CMD_VALID,
  input wire scfg_pkg::scfg_kind_t CMD_KIND,
  input wire logic [7:0] CMD_OP,
  input wire logic [23:0] CMD_ADDR,
  input wire logic [7:0] CMD_WDATA,
  input wire logic [1:0] CMD_LAT,
  output logic CMD_READY,
  output logic RESP_VALID,
  output logic [7:0] RESP_DATA,
  output logic RESP_ERR
);
  typedef enum {H_IDLE, H_SHIFT, H_END, H_PULSE} scfg_hstate_t;
  localparam logic FAST_SCK = (scfg_pkg::SCK_MHZ > scfg_pkg::ZERO_LAT_MAX_MHZ);

  scfg_hstate_t state, next_state;
  logic [39:0] out_sh, next_out_sh;
  logic [7:0] in_sh, next_in_sh;
  logic [5:0] bi, next_bi, nout, next_nout, tot, next_tot;
  logic ph, next_ph, sck, next_sck, cs_n, next_cs_n, rst_n, next_rst_n, wake, next_wake;
  logic [scfg_pkg::TIMER_W-1:0] tcnt, next_tcnt;
  logic [2:0] div, next_div;
  logic ready, next_ready, rv, next_rv, rerr, next_rerr;
  logic [7:0] rdata, next_rdata;
  logic so_m, so_s;
  logic tick;

  // =====================================================
  // pin synchroniser
  always_ff @(posedge CLOCK) begin
    so_m <= LINK.so;
    so_s <= so_m;
  end

  assign tick = (div == 3'(scfg_pkg::SCK_HALF - 1));

  // =====================================================
  // link sequencer
  always_comb begin
    next_state = state;
    next_out_sh = out_sh;
    next_in_sh = in_sh;
    next_bi = bi;
    next_nout = nout;
    next_tot = tot;
    next_ph = ph;
    next_sck = sck;
    next_cs_n = cs_n;
    next_rst_n = rst_n;
    next_wake = wake;
    next_tcnt = tcnt;
    next_div = tick ? 3'h0 : div + 3'h1;
    next_ready = ready;
    next_rv = 1'b0;
    next_rerr = rerr;
    next_rdata = rdata;
    case (state)
      H_IDLE: begin
        next_div = 3'h0;
        if (CMD_VALID && ready) begin
          next_ready = 1'b0;
          next_bi = 6'h0;
          next_ph = 1'b0;
          next_out_sh = {CMD_OP, CMD_ADDR, CMD_WDATA};
          next_rerr = 1'b0;
          next_tcnt = '0;
          case (CMD_KIND)
            scfg_pkg::K_WRITE_ANY: begin
              next_nout = 6'd40;
              next_tot = 6'd40;
            end
            scfg_pkg::K_READ_ANY: begin
              next_nout = 6'd32;
              next_tot = 6'd40 + {4'h0, CMD_LAT};
            end
            scfg_pkg::K_READ_REG: begin
              next_nout = 6'd8;
              next_tot = 6'd16 + {4'h0, CMD_LAT};
            end
            default: begin
              next_nout = 6'd8;
              next_tot = 6'd8;
            end
          endcase
          if (CMD_KIND == scfg_pkg::K_WAKE) begin
            next_cs_n = 1'b0;
            next_wake = 1'b1;
            next_state = H_PULSE;
          end else if (CMD_KIND == scfg_pkg::K_HW_RESET) begin
            next_rst_n = 1'b0;
            next_wake = 1'b0;
            next_state = H_PULSE;
          end else if (FAST_SCK && CMD_LAT == 2'h0 && (CMD_KIND == scfg_pkg::K_READ_ANY ||
                       CMD_KIND == scfg_pkg::K_READ_REG)) begin
            // zero latency is refused above the safe clock rate
            next_rerr = 1'b1;
            next_rv = 1'b1;
            next_ready = 1'b1;
          end else begin
            next_cs_n = 1'b0;
            next_state = H_SHIFT;
          end
        end else if (!CMD_VALID && !rv) begin
          next_ready = 1'b1;
        end
      end
      H_SHIFT: begin
        if (tick) begin
          if (!ph) begin
            next_ph = 1'b1;
            next_sck = 1'b1;
          end else begin
            next_ph = 1'b0;
            next_sck = 1'b0;
            next_out_sh = {out_sh[38:0], 1'b0};
            if (bi >= tot - 6'd8 && tot != nout) begin
              next_in_sh = {in_sh[6:0], so_s};
            end
            next_bi = bi + 6'h1;
            if (bi == tot - 6'h1) begin
              next_state = H_END;
            end
          end
        end
      end
      H_END: begin
        if (tick) begin
          if (!cs_n) begin
            next_cs_n = 1'b1;
          end else begin
            next_rdata = in_sh;
            next_rv = 1'b1;
            next_ready = 1'b1;
            next_state = H_IDLE;
          end
        end
      end
      H_PULSE: begin
        next_div = 3'h0;
        next_tcnt = tcnt + 1'b1;
        if (tcnt == scfg_pkg::TIMER_W'(wake ? scfg_pkg::WAKE_PULSE_CYC : scfg_pkg::HWRST_CYC)) begin
          next_cs_n = 1'b1;
          next_rst_n = 1'b1;
          next_rv = 1'b1;
          next_ready = 1'b1;
          next_state = H_IDLE;
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state <= H_IDLE;
      out_sh <= '0;
      in_sh <= 8'h00;
      bi <= 6'h0;
      nout <= 6'h0;
      tot <= 6'h0;
      ph <= 1'b0;
      sck <= 1'b0;
      cs_n <= 1'b1;
      rst_n <= 1'b1;
      wake <= 1'b0;
      tcnt <= '0;
      div <= 3'h0;
      ready <= 1'b0;
      rv <= 1'b0;
      rerr <= 1'b0;
      rdata <= 8'h00;
    end else begin
      state <= next_state;
      out_sh <= next_out_sh;
      in_sh <= next_in_sh;
      bi <= next_bi;
      nout <= next_nout;
      tot <= next_tot;
      ph <= next_ph;
      sck <= next_sck;
      cs_n <= next_cs_n;
      rst_n <= next_rst_n;
      wake <= next_wake;
      tcnt <= next_tcnt;
      div <= next_div;
      ready <= next_ready;
      rv <= next_rv;
      rerr <= next_rerr;
      rdata <= next_rdata;
    end
  end

  assign LINK.sck = sck;
  assign LINK.cs_n = cs_n;
  assign LINK.si = out_sh[39];
  assign LINK.reset_n = rst_n;
  assign CMD_READY = ready;
  assign RESP_VALID = rv;
  assign RESP_DATA = rdata;
  assign RESP_ERR = rerr;
endmodule

// ---- tb/scfg_link_props.sv ----
// protocol checker for the serial link between host and device ends
`timescale 1ns/1ps
module scfg_link_props (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_oe_n,
  input wire logic reset_n
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ==========================================================
  // helper: length of the current pin reset pulse
  logic [7:0] rst_len;
  logic [7:0] next_rst_len;
  always_comb begin
    next_rst_len = reset_n ? 8'h00 : rst_len + 8'h01;
  end
  always_ff @(posedge CLOCK) begin
    rst_len <= SYS_RST ? 8'h00 : next_rst_len;
  end
  // ==========================================================
  // assertions
  AST_RST_IDLE: assert property (disable iff (1'b0) SYS_RST |=> (cs_n && !sck && reset_n && so_oe_n))
    else $error("link not idle after reset");
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("serial clock high outside a frame");
  AST_SCK_HALF: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("serial clock high phase not four cycles");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("chip select gap too short");
  AST_SI_STABLE: assert property (sck && $past(sck) |-> $stable(si))
    else $error("host data changed while clock high");
  AST_SO_RELEASE: assert property (cs_n [*6] |-> so_oe_n)
    else $error("device drives data with chip select high");
  AST_PIN_RST_WIDTH: assert property ($rose(reset_n) |-> rst_len >= scfg_pkg::HWRST_CYC)
    else $error("pin reset pulse too short");
  AST_RST_OUTSIDE: assert property (!reset_n |-> cs_n && !sck)
    else $error("pin reset inside a frame");
  // ==========================================================
  // covers
  COV_FRAME: cover property ($fell(cs_n));
  COV_READ: cover property ($rose(sck) && !so_oe_n);
  COV_PIN_RST: cover property ($fell(reset_n));
endmodule

// ---- tb/spi_memory_config_regs_four_five_tb.sv ----
// self-checking bench: host and device ends joined across the serial link
`timescale 1ns/1ps
module spi_memory_config_regs_four_five_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  scfg_pkg::scfg_kind_t cmd_kind = scfg_pkg::K_OPCODE_ONLY;
  logic [7:0] cmd_op = 8'h00;
  logic [23:0] cmd_addr = 24'h000000;
  logic [7:0] cmd_wdata = 8'h00;
  logic [1:0] cmd_lat = 2'h0;
  logic cmd_ready;
  logic resp_valid;
  logic resp_err;
  logic [7:0] resp_data;
  logic [2:0] drive_code;
  logic powered_down;
  logic [1:0] latency;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 94;
  int resp_seen = 0;
  int issued = 0;
  int i;
  logic [31:0] tmp;
  logic [7:0] d;
  logic [1:0] lat = 2'h0;
  logic [9:0] note;
  logic [9:0] exp_q[$];
  always #4 clock = ~clock;
  scfg_link_if scfg_link_if_inst ();
  scfg_host scfg_host_inst (.CLOCK(clock), .SYS_RST(sys_rst), .LINK(scfg_link_if_inst), .CMD_VALID(cmd_valid),
    .CMD_KIND(cmd_kind), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .CMD_LAT(cmd_lat),
    .CMD_READY(cmd_ready), .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .RESP_ERR(resp_err));
  scfg_device scfg_device_inst (.CLOCK(clock), .SYS_RST(sys_rst), .LINK(scfg_link_if_inst),
    .DRIVE_CODE(drive_code), .POWERED_DOWN(powered_down), .LATENCY(latency));
  scfg_link_props scfg_link_props_inst (.CLOCK(clock), .SYS_RST(sys_rst), .sck(scfg_link_if_inst.sck),
    .cs_n(scfg_link_if_inst.cs_n), .si(scfg_link_if_inst.si), .so_oe_n(scfg_link_if_inst.so_oe_n),
    .reset_n(scfg_link_if_inst.reset_n));
  // ==========================================================
  // compare and report
  task automatic chk_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // host commands; the expected answer is queued before the request
  task automatic cmd(input scfg_pkg::scfg_kind_t k, input logic [7:0] op, input logic [23:0] a,
      input logic [7:0] wd, input logic chk, input logic [7:0] exp);
    int n;
    exp_q.push_back({chk, 1'b0, exp});
    issued++;
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= wd;
    cmd_lat <= lat;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (cmd_ready !== 1'b1 && n < 2000);
    cmd_valid <= 1'b0;
    for (n = 0; n < 2000 && resp_seen < issued; n++) @(posedge clock);
    if (resp_seen < issued) begin
      n_mismatch++;
      $display("[FAIL] response expected 1 seen 0");
      wrap_up();
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] wd);
    cmd(scfg_pkg::K_WRITE_ANY, scfg_pkg::OP_WRITE_ANY, a, wd, 1'b0, 8'h00);
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] exp);
    cmd(scfg_pkg::K_READ_ANY, scfg_pkg::OP_READ_ANY, a, 8'h00, 1'b1, exp);
  endtask
  task automatic rreg(input logic [7:0] op, input logic [7:0] exp);
    cmd(scfg_pkg::K_READ_REG, op, 24'h000000, 8'h00, 1'b1, exp);
  endtask
  task automatic pin_reset();
    cmd(scfg_pkg::K_HW_RESET, 8'h00, 24'h000000, 8'h00, 1'b0, 8'h00);
    // the device reloads several cycles after the host reports the pulse done
    repeat (8) @(posedge clock);
  endtask
  // results are paired with the oldest note as they appear
  always @(posedge clock) begin
    if (resp_valid === 1'b1) begin
      note = exp_q.pop_front();
      chk_bit("resp_err", note[8], resp_err);
      if (note[9]) chk_val("resp_data", note[7:0], resp_data);
      resp_seen++;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    chk_val("drive_code", 8'h04, {5'h00, drive_code});
    chk_val("latency", 8'h00, {6'h00, latency});
    chk_bit("powered_down", 1'b0, powered_down);
    rreg(scfg_pkg::OP_READ_CONFIG_FIVE, scfg_pkg::CFG5_FACTORY);
    rd(scfg_pkg::ADDR_CFG5_NV, 8'h00);
    rd(scfg_pkg::ADDR_CFG4_V, scfg_pkg::CFG4_FACTORY);
    $display("test factory done");
    for (int l = 0; l < 4; l++) begin
      tmp = $random(seed);
      d = {l[1:0], tmp[5:0]};
      wr(scfg_pkg::ADDR_CFG5_V, d);
      lat = l[1:0];
      repeat (4) @(posedge clock);
      chk_val("latency", {6'h00, lat}, {6'h00, latency});
      rreg(scfg_pkg::OP_READ_CONFIG_FIVE, d & 8'hC0);
      rd(scfg_pkg::ADDR_CFG5_V, d & 8'hC0);
      rreg(scfg_pkg::OP_READ_CONFIG_FOUR, 8'h08);
      rreg(scfg_pkg::OP_READ_STATUS_ONE, 8'h00);
    end
    rd(scfg_pkg::ADDR_CFG5_NV, 8'h00);
    wr(scfg_pkg::ADDR_CFG5_NV, 8'hBF);
    rd(scfg_pkg::ADDR_CFG5_NV, 8'h80);
    chk_val("latency", 8'h03, {6'h00, latency});
    pin_reset();
    lat = 2'h2;
    chk_val("latency", 8'h02, {6'h00, latency});
    rreg(scfg_pkg::OP_READ_CONFIG_FIVE, 8'h80);
    $display("test latency done");
    for (int c = 0; c < 7; c++) begin
      wr(scfg_pkg::ADDR_CFG4_V, {c[2:0], 5'h08});
      repeat (4) @(posedge clock);
      chk_val("drive_code", {5'h00, (c == 0) ? 3'h4 : c[2:0]}, {5'h00, drive_code});
      rd(scfg_pkg::ADDR_CFG4_V, {c[2:0], 5'h08});
    end
    $display("test drive done");
    wr(scfg_pkg::ADDR_CFG4_NV, 8'h0C);
    pin_reset();
    chk_bit("powered_down", 1'b1, powered_down);
    cmd(scfg_pkg::K_WAKE, 8'h00, 24'h000000, 8'h00, 1'b0, 8'h00);
    chk_bit("powered_down", 1'b1, powered_down);
    for (i = 0; i < scfg_pkg::EXIT_CYC + 40 && powered_down !== 1'b0; i++) @(posedge clock);
    chk_bit("powered_down", 1'b0, powered_down);
    chk_bit("exit_wait", 1'b1, i >= scfg_pkg::EXIT_CYC - 10);
    rd(scfg_pkg::ADDR_CFG4_V, 8'h0C);
    $display("test power-down done");
    wr(scfg_pkg::ADDR_CFG4_V, 8'hA8);
    cmd(scfg_pkg::K_OPCODE_ONLY, scfg_pkg::OP_SOFT_RESET, 24'h000000, 8'h00, 1'b0, 8'h00);
    repeat (4) @(posedge clock);
    chk_bit("powered_down", 1'b0, powered_down);
    chk_val("drive_code", 8'h04, {5'h00, drive_code});
    rd(scfg_pkg::ADDR_CFG4_V, 8'h0C);
    $display("test soft reset done");
    wrap_up();
  end
endmodule
